// >>> lfw_cfg.svh
// Constants for the low-frequency watchdog: offsets, fields, reset values
`ifndef LFW_CFG_SVH
`define LFW_CFG_SVH
`define LFW_ADDR_W 12
`define LFW_IDX_START 10'h0af
`define LFW_IDX_MODE 10'h0b0
`define LFW_IDX_STATUS 10'h0b1
`define LFW_IDX_COUNT 10'h0b2
`define LFW_START_RST 16'h0000
`define LFW_MODE_RST 2'h0
`define LFW_LOW_PAD 8'h00
`define LFW_CNT_W 24
`define LFW_LF_HZ 32768
`define LFW_BYTE_HI 15
`define LFW_BYTE_LO 8
`endif

// >>> lfw_pkg.sv
// Types shared by the low-frequency watchdog modules
package lfw_pkg;
  // Byte steering for the start-value register
  typedef enum logic [1:0] {
    LFW_BYTE_LOW = 2'b01,
    LFW_BYTE_HIGH = 2'b10
  } lfw_byte_e;
  // Power modes as seen by the watchdog
  typedef enum logic [1:0] {
    LFW_PM_ACTIVE = 2'h0,
    LFW_PM_MEMRET_TIMERS = 2'h1,
    LFW_PM_REGRET = 2'h2,
    LFW_PM_MEMRET_OFF = 2'h3
  } lfw_pm_e;
  typedef logic [23:0] lfw_count_t;
endpackage

// >>> lfw_cnt_if.sv
// Control link between the register side and the countdown core
`timescale 1ns/1ps
interface lfw_cnt_if;
  logic tick;
  logic load;
  logic [15:0] load_val;
  logic run;
  lfw_pkg::lfw_count_t count;
  logic expire;
  modport ctl (output tick, output load, output load_val, output run,
    input count, input expire);
  modport cnt (input tick, input load, input load_val, input run,
    output count, output expire);
endinterface

// >>> lfw_counter.sv
// Countdown core: 24-bit counter stepped by low-frequency ticks
`timescale 1ns/1ps
`include "lfw_cfg.svh"
module lfw_counter (
  input wire logic clk,
  input wire logic rst,
  lfw_cnt_if.cnt cif
);
  lfw_pkg::lfw_count_t count_r;
  lfw_pkg::lfw_count_t count_nxt;
  logic at_one;

  // Zero start value decrements through the wrap: 2^24 ticks
  assign at_one = (count_r == lfw_pkg::lfw_count_t'(1));
  assign cif.expire = cif.run & cif.tick & at_one; // [R8]
  assign cif.count = count_r;

  // Reload wins over a tick in the same cycle for the count; expire ignores load and still fires on that tick
  always_comb begin
    count_nxt = count_r;
    if (cif.load) begin
      count_nxt = {cif.load_val, `LFW_LOW_PAD}; // [R10]
    end else if (cif.run && cif.tick) begin
      count_nxt = count_r - lfw_pkg::lfw_count_t'(1); // [R13]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_reload_value: assert property ( // [R10]
    cif.load |=> count_r == {$past(cif.load_val), `LFW_LOW_PAD})
    else $error("counter not reloaded with start value times 256");
  chk_step_one: assert property ( // [R13]
    (!cif.load && cif.run && cif.tick)
      |=> count_r == $past(count_r) - 24'h000001)
    else $error("counter did not step by one per tick");
  chk_zero_wraps: assert property ( // [R14]
    (!cif.load && cif.run && cif.tick && count_r == 0)
      |=> count_r == 24'hffffff)
    else $error("zero start value did not wrap to full count");
endmodule

// >>> lfw_watchdog.sv
// Low-frequency watchdog with APB register access and system reset request
//
// Overview of operation
// [R1] Start value is 16 bits, forming counter bits 23:8; low byte zero.
// [R2] Start value goes as two byte accesses, low byte then high byte.
// [R3] First read after any write of the register returns the low byte.
// [R4] First write after any read of the register goes to the low byte.
// [R5] Reading the register returns the stored start value, not live count.
// [R6] After reset the watchdog is idle and the start value is zero.
// [R7] Watchdog activates only after both bytes have been written.
// [R8] Active counter decrements from value times 256; zero resets the system.
// [R9] Watchdog reset has the same effect as power-on or pin reset.
// [R10] Each completed write reloads the counter and restarts the countdown.
// [R11] Software rewrites the value often enough to avoid reaching zero.
// [R12] Counter steps on the 32.768 kHz clock; software keeps it enabled.
// [R13] Timeout equals value times 256 over 32768 seconds, one tick per step.
// [R14] Start value zero gives the 512 second maximum, not disabled.
// [R15] Software cannot stop it; only reset or retention modes disable it.
// [R16] In memory retention with timers on it keeps counting.
// [R17] Low byte write is buffered; high byte write activates and reloads.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "lfw_cfg.svh"
module lfw_watchdog (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LF_CLK,
  output logic WDT_RESET_REQ,
  output logic WDT_ACTIVE
);
  lfw_cnt_if cif ();

  // Word addresses: register index times four
  localparam logic [11:0] ADDR_START = {`LFW_IDX_START, 2'b00};
  localparam logic [11:0] ADDR_MODE = {`LFW_IDX_MODE, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {`LFW_IDX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_COUNT = {`LFW_IDX_COUNT, 2'b00};

  logic [15:0] start_r;
  logic [7:0] low_buf_r;
  lfw_pkg::lfw_byte_e wr_sel_r;
  lfw_pkg::lfw_byte_e wr_sel_nxt;
  lfw_pkg::lfw_byte_e rd_sel_r;
  lfw_pkg::lfw_byte_e rd_sel_nxt;
  lfw_pkg::lfw_pm_e mode_r;
  logic active_r;
  logic active_nxt;
  logic rst_req_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rdata;
  logic lf_s1_r;
  logic lf_s2_r;
  logic lf_d_r;

  // APB decode; the answer is one wait state after the access phase opens
  wire access = PSEL & PENABLE;
  wire first_acc = access & ~pready_r;
  wire done = access & pready_r;
  wire hit_start = (PADDR == ADDR_START);
  wire hit_mode = (PADDR == ADDR_MODE);
  wire hit_status = (PADDR == ADDR_STATUS);
  wire hit_count = (PADDR == ADDR_COUNT);
  wire mapped = hit_start | hit_mode | hit_status | hit_count;
  wire ro_hit = hit_status | hit_count;
  wire bad = ~mapped | (PWRITE & ro_hit);
  wire wr_start = done & PWRITE & hit_start;
  wire rd_start = done & ~PWRITE & hit_start;
  wire wr_mode = done & PWRITE & hit_mode;
  wire wr_high = wr_start & (wr_sel_r == lfw_pkg::LFW_BYTE_HIGH);
  wire [7:0] wbyte = PWDATA[7:0];

  // Retention modes without timers stop the watchdog; timers-on keeps it
  wire pm_stop = (mode_r == lfw_pkg::LFW_PM_REGRET) ||
    (mode_r == lfw_pkg::LFW_PM_MEMRET_OFF); // [R15]

  // Low-frequency pin is sampled twice before use; edge taken after that
  wire lf_rise = lf_s2_r & ~lf_d_r; // [R12]

  // Read mux: the start register yields the stored value only
  wire [7:0] start_byte = (rd_sel_r == lfw_pkg::LFW_BYTE_LOW) ?
    start_r[7:0] : start_r[`LFW_BYTE_HI:`LFW_BYTE_LO]; // [R5]
  always_comb begin
    rdata = '0;
    if (hit_start) begin
      rdata = {24'h000000, start_byte};
    end else if (hit_mode) begin
      rdata = {30'h00000000, mode_r};
    end else if (hit_status) begin
      rdata = {29'h00000000, rd_sel_r == lfw_pkg::LFW_BYTE_HIGH,
        wr_sel_r == lfw_pkg::LFW_BYTE_HIGH, active_r};
    end else if (hit_count) begin
      rdata = {8'h00, cif.count};
    end
  end

  // Byte steering: writes and reads each reset the other's pointer
  always_comb begin
    wr_sel_nxt = wr_sel_r;
    rd_sel_nxt = rd_sel_r;
    if (wr_start) begin
      rd_sel_nxt = lfw_pkg::LFW_BYTE_LOW; // [R3]
      wr_sel_nxt = wr_high ? lfw_pkg::LFW_BYTE_LOW :
        lfw_pkg::LFW_BYTE_HIGH; // [R2]
    end else if (rd_start) begin
      wr_sel_nxt = lfw_pkg::LFW_BYTE_LOW; // [R4]
      rd_sel_nxt = (rd_sel_r == lfw_pkg::LFW_BYTE_HIGH) ?
        lfw_pkg::LFW_BYTE_LOW : lfw_pkg::LFW_BYTE_HIGH; // [R2]
    end
  end

  // Only a completed pair arms; a retention stop disarms
  always_comb begin
    active_nxt = active_r;
    if (wr_high) begin
      active_nxt = 1'b1; // [R7]
    end else if (pm_stop) begin
      active_nxt = 1'b0; // [R15]
    end
  end

  // Countdown core controls
  assign cif.tick = lf_rise;
  assign cif.load = wr_high; // [R17]
  assign cif.load_val = {wbyte, low_buf_r}; // [R1]
  assign cif.run = active_r & ~pm_stop; // [R16]

  lfw_counter u_counter (
    .clk(SYS_CLK),
    .rst(RST),
    .cif(cif)
  );

  // Synchroniser for the low-frequency clock pin
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      lf_s1_r <= 1'b0;
      lf_s2_r <= 1'b0;
      lf_d_r <= 1'b0;
    end else begin
      lf_s1_r <= LF_CLK;
      lf_s2_r <= lf_s1_r;
      lf_d_r <= lf_s2_r;
    end
  end

  // APB answer registers
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= first_acc;
      pslverr_r <= first_acc & bad;
      prdata_r <= first_acc ? rdata : prdata_r;
    end
  end

  // Start value: low byte buffered until the high byte completes it
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      start_r <= `LFW_START_RST; // [R6]
      low_buf_r <= `LFW_LOW_PAD;
    end else if (wr_start && !wr_high) begin
      low_buf_r <= wbyte; // [R17]
    end else if (wr_high) begin
      start_r <= {wbyte, low_buf_r}; // [R2]
    end
  end

  // Pointers, mode and arming state
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      wr_sel_r <= lfw_pkg::LFW_BYTE_LOW;
      rd_sel_r <= lfw_pkg::LFW_BYTE_LOW;
      mode_r <= lfw_pkg::LFW_PM_ACTIVE;
      active_r <= 1'b0; // [R6]
    end else begin
      wr_sel_r <= wr_sel_nxt;
      rd_sel_r <= rd_sel_nxt;
      mode_r <= wr_mode ? lfw_pkg::lfw_pm_e'(PWDATA[1:0]) : mode_r;
      active_r <= active_nxt;
    end
  end

  // Reset request holds until the system reset comes back round
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rst_req_r <= 1'b0;
    end else if (cif.expire) begin
      rst_req_r <= 1'b1; // [R9]
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign WDT_RESET_REQ = rst_req_r;
  assign WDT_ACTIVE = active_r;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_low_write;
    wr_start && wr_sel_r == lfw_pkg::LFW_BYTE_LOW;
  endsequence
  sequence s_high_write;
    wr_start && wr_sel_r == lfw_pkg::LFW_BYTE_HIGH;
  endsequence

  chk_pair_arms: assert property ( // [R7]
    s_low_write ##1 (!wr_start && !rd_start)[*1] ##[0:40] s_high_write
      |=> active_r)
    else $error("pair of byte writes did not arm the watchdog");
  chk_low_only: assert property ( // [R17]
    (s_low_write and !active_r) |=> !active_r && !$changed(start_r))
    else $error("low byte write alone took effect");
  chk_read_after_write: assert property ( // [R3]
    wr_start |=> rd_sel_r == lfw_pkg::LFW_BYTE_LOW)
    else $error("read after write not steered to low byte");
  chk_write_after_read: assert property ( // [R4]
    rd_start |=> wr_sel_r == lfw_pkg::LFW_BYTE_LOW)
    else $error("write after read not steered to low byte");
  chk_read_stored: assert property ( // [R5]
    (first_acc && !PWRITE && hit_start &&
      rd_sel_r == lfw_pkg::LFW_BYTE_HIGH)
      |=> PRDATA == {24'h000000, start_r[15:8]})
    else $error("start register read did not return stored value");
  chk_expire_reset: assert property ( // [R8]
    cif.expire |=> WDT_RESET_REQ [*2])
    else $error("counter reaching zero did not request reset");
  chk_no_sw_stop: assert property ( // [R15]
    (active_r && !pm_stop) |=> active_r)
    else $error("watchdog stopped without reset or retention mode");
  chk_timers_on_run: assert property ( // [R16]
    (active_r && mode_r == lfw_pkg::LFW_PM_MEMRET_TIMERS) |-> cif.run)
    else $error("watchdog halted in timers-on retention");
  chk_idle_after_reset: assert property ( // [R6]
    $fell(RST) |-> !active_r && start_r == 16'h0000 && !WDT_RESET_REQ)
    else $error("watchdog not idle after reset");
  chk_apb_answer: assert property (
    first_acc |=> PREADY ##1 !PREADY)
    else $error("APB answer not one cycle after access phase");
  // Each byte write moves the write pointer; each read moves the read one
  chk_writes_alternate: assert property ( // [R2]
    wr_start |=> wr_sel_r != $past(wr_sel_r))
    else $error("write pointer did not alternate");
  chk_reads_alternate: assert property ( // [R2]
    rd_start |=> rd_sel_r != $past(rd_sel_r))
    else $error("read pointer did not alternate");
  // The low byte waits in the buffer until its partner arrives
  chk_low_buffered: assert property ( // [R17]
    s_low_write |=> low_buf_r == $past(wbyte) &&
      wr_sel_r == lfw_pkg::LFW_BYTE_HIGH)
    else $error("low byte not buffered for the pair");
  // The high byte completes the word and restarts the count from it
  chk_high_stores: assert property ( // [R1]
    s_high_write |=> start_r == {$past(wbyte), $past(low_buf_r)})
    else $error("high byte write did not store the full value");
  chk_high_reloads: assert property ( // [R10]
    s_high_write |=> cif.count == {start_r, `LFW_LOW_PAD})
    else $error("counter not restarted from stored value times 256");
  chk_read_low: assert property ( // [R5]
    (first_acc && !PWRITE && hit_start &&
      rd_sel_r == lfw_pkg::LFW_BYTE_LOW)
      |=> PRDATA == {24'h000000, start_r[7:0]})
    else $error("low byte read did not return stored value");
  // Idle until a pair arrives, and the count stays put while idle
  chk_stays_idle: assert property ( // [R7]
    (!active_r && !wr_high) |=> !active_r)
    else $error("watchdog armed without a completed pair");
  chk_idle_no_count: assert property ( // [R6]
    (!active_r && !cif.load) |=> $stable(cif.count))
    else $error("idle watchdog counter moved");
  chk_retention_stop: assert property ( // [R15]
    (active_r && pm_stop && !wr_high) |=> !active_r)
    else $error("retention mode without timers did not disarm");
  // Reset request: only after expiry, then held until system reset
  chk_no_early_req: assert property ( // [R8]
    (!WDT_RESET_REQ && !cif.expire) |=> !WDT_RESET_REQ)
    else $error("reset requested before the count reached zero");
  chk_req_holds: assert property ( // [R9]
    WDT_RESET_REQ |=> WDT_RESET_REQ)
    else $error("reset request dropped before system reset");
  // One tick per pin rise, never two in a row
  chk_single_tick: assert property ( // [R12]
    cif.tick |=> !cif.tick)
    else $error("one pin rise gave more than one tick");
  // Refused accesses answer with an error and change nothing
  chk_bad_access: assert property (
    (first_acc && bad) |=> PSLVERR && PREADY)
    else $error("refused access did not raise the error response");
  chk_bad_no_effect: assert property (
    (done && bad) |=> $stable(start_r) && $stable(mode_r))
    else $error("refused access changed a register");
  // Mode register takes the written code at the committing edge
  chk_mode_write: assert property (
    wr_mode |=> mode_r == $past(PWDATA[1:0]))
    else $error("mode register did not take the written code");
endmodule

// >>> lfw_tb.sv
// Self-checking testbench for the low-frequency watchdog
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] A_START = 12'h2bc;
  localparam logic [11:0] A_MODE = 12'h2c0;
  localparam logic [11:0] A_STAT = 12'h2c4;
  localparam logic [11:0] A_CNT = 12'h2c8;
  localparam logic [11:0] A_NONE = 12'h100;
  typedef struct {
    logic w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] rd;
    logic err;
    logic act;
  } lfw_row_s;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic lf_clk = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wdt_reset_req;
  logic wdt_active;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int samples_checked = 0;
  lfw_row_s rows[20] = '{
    '{0, A_START, 0, 0, 0, 0}, '{0, A_START, 0, 0, 0, 0},
    '{1, A_START, 8'h34, 0, 0, 0}, '{1, A_START, 8'h12, 0, 0, 1},
    '{0, A_START, 0, 8'h34, 0, 1}, '{0, A_STAT, 0, 32'h5, 0, 1},
    '{0, A_START, 0, 8'h12, 0, 1}, '{1, A_START, 8'h55, 0, 0, 1},
    '{0, A_STAT, 0, 32'h3, 0, 1}, '{0, A_START, 0, 8'h34, 0, 1},
    '{1, A_START, 8'h66, 0, 0, 1}, '{1, A_START, 8'h00, 0, 0, 1},
    '{0, A_START, 0, 8'h66, 0, 1}, '{0, A_START, 0, 8'h00, 0, 1},
    '{0, A_CNT, 0, 32'h6600, 0, 1}, '{0, A_NONE, 0, 0, 1, 1},
    '{1, A_STAT, 8'h07, 0, 1, 1}, '{1, A_CNT, 8'h01, 0, 1, 1},
    '{1, A_MODE, 8'h01, 0, 0, 1}, '{0, A_MODE, 0, 8'h01, 0, 1}};

  lfw_watchdog uut (
    .SYS_CLK(sys_clk),
    .RST(rst),
    .PSEL(psel),
    .PENABLE(penable),
    .PWRITE(pwrite),
    .PADDR(paddr),
    .PWDATA(pwdata),
    .PRDATA(prdata),
    .PREADY(pready),
    .PSLVERR(pslverr),
    .LF_CLK(lf_clk),
    .WDT_RESET_REQ(wdt_reset_req),
    .WDT_ACTIVE(wdt_active)
  );

  // 125 MHz system clock
  always #4 sys_clk = ~sys_clk;

  // Compare and count; four-state equality so X never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; waits for pready, data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1);
    chk(n, 2);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Low-frequency ticks: held 4 cycles high and at least 5 low so each is seen once
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      lf_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      lf_clk <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic arm(input logic [7:0] lo, input logic [7:0] hi);
    apb(1'b1, A_START, {24'h0, lo});
    apb(1'b1, A_START, {24'h0, hi});
  endtask

  // Hang guard, well above the few thousand cycles the tests need
  initial begin
    #(8 * 20000);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    chk({wdt_active, wdt_reset_req}, 2'b00);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk(rd, rows[i].rd);
      chk(err, rows[i].err);
      @(posedge sys_clk);
      chk(wdt_active, rows[i].act);
    end
    apb(1'b1, A_MODE, 32'h0);
    // Value 1: 256 ticks to expiry; reload just before it
    arm(8'h01, 8'h00);
    ticks(255);
    apb(1'b0, A_CNT, 32'h0);
    chk(rd, 32'h1);
    chk(wdt_reset_req, 1'b0);
    arm(8'h01, 8'h00);
    apb(1'b0, A_CNT, 32'h0);
    chk(rd, 32'h100);
    ticks(255);
    chk(wdt_reset_req, 1'b0);
    ticks(1);
    chk(wdt_reset_req, 1'b1);
    // Second reset in mid-run clears everything
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk({wdt_active, wdt_reset_req}, 2'b00);
    apb(1'b0, A_START, 32'h0);
    chk(rd, 32'h0);
    // Zero start value wraps the full 24 bits and stays armed
    arm(8'h00, 8'h00);
    // Arming lands at the committing edge; look one edge later
    @(posedge sys_clk);
    chk(wdt_active, 1'b1);
    ticks(1);
    apb(1'b0, A_CNT, 32'h0);
    chk(rd, 32'hffffff);
    chk(wdt_reset_req, 1'b0);
    // Timers-on retention keeps counting; register retention disarms
    apb(1'b1, A_MODE, 32'h1);
    ticks(1);
    apb(1'b0, A_CNT, 32'h0);
    chk(rd, 32'hfffffe);
    apb(1'b1, A_MODE, 32'h2);
    // Mode lands at the commit edge, disarm one edge after that
    repeat (2) @(posedge sys_clk);
    chk(wdt_active, 1'b0);
    apb(1'b1, A_MODE, 32'h0);
    @(posedge sys_clk);
    chk(wdt_active, 1'b0);
    end_of_test();
  end
endmodule
